// [edge_sync.v]
`timescale 1ns/1ps
// Brings an asynchronous slow clock into sys_clk and marks each rising edge
module edge_sync (
    input  wire sys_clk,
    input  wire rstn,
    input  wire async_in,
    output wire rise_pulse
);
    reg meta_q;
    reg sync_q;
    reg prev_q;

    // ==========================================================
    // Two flops, then an edge detector on the settled copy only
    always @(posedge sys_clk) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise_pulse = sync_q & ~prev_q;
endmodule

// [periodic_timer_and_fm_control.v]
`timescale 1ns/1ps
`include "periodic_timer_defs.vh"

module periodic_timer_and_fm_control (
    input  wire       sys_clk,
    input  wire       rstn,
    // Register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Unit status and controls
    input  wire       register_lock_flag,
    input  wire       loop_clock_select,
    input  wire       osc_ready_flag,
    input  wire       stop_mode,
    input  wire       pseudo_stop_select,
    // Clocks from pins
    input  wire       internal_rc_clock,
    input  wire       external_osc_clock,
    input  wire       reference_clock,
    // Effects on the rest of the unit
    output reg        clear_lock_status,
    output reg        clear_osc_ready,
    output reg        modulation_amplitude_hi,
    output reg        modulation_amplitude_lo,
    output reg        modulation_tick,
    output reg        modulation_phase,
    output reg        periodic_clock_select,
    output reg        periodic_tick,
    output wire       irq
);
    // ==========================================================
    // Overview
    // Two independent jobs share this block.
    //
    // Modulation: a two-bit amplitude field, guarded by the
    // lock flag and the loop clock select. An accepted write
    // also sends one-cycle clear requests for the lock and
    // oscillator-ready status, as the loop must settle again.
    // While the amplitude is not zero a square wave toggles at
    // the reference rate over sixteen.
    //
    // Periodic timer: a prescaler and a modulus counter that
    // advance on rising edges of the selected source clock.
    // Each completed period sets a sticky status bit and
    // gives a one-cycle tick; the next period starts alone.
    //
    // Clocking: only sys_clk runs in here. Pin clocks become
    // one-cycle edge pulses, which costs two or three cycles
    // of latency but keeps a single domain.
    //
    // Limitation: each pin clock must stay high and low for
    // at least two sys_clk cycles, or edges are lost and the
    // periods come out long. Nothing flags such a loss.
    //
    // Restart: any timer control write and any change of the
    // clock select clear both counters. A restart that meets
    // a time-out in one cycle wins, so no request escapes
    // from a period that software has just abandoned.
    //
    // Stop mode halts counting without clearing it, except in
    // pseudo stop with the oscillator selected and enabled.

    // ==========================================================
    // State
    // Counters are wide enough for the largest decimal prescale
    reg  [7:0]  timer_ctrl_q;
    reg         pstop_en_q;
    reg  [1:0]  irq_status_q;
    reg  [1:0]  irq_mask_q;
    reg  [17:0] pre_cnt_q;
    reg  [3:0]  mod_cnt_q;
    reg  [3:0]  ref_cnt_q;
    reg         clksel_d;
    reg         restart;
    reg         timeout;
    reg  [17:0] pre_limit;

    wire        rc_rise;
    wire        osc_rise;
    wire        ref_rise;
    wire        wr_mod;
    wire        wr_timer;
    wire        wr_cfg;
    wire        decimal_sel;
    wire [2:0]  rate_sel;
    wire [3:0]  modulus_sel;
    wire        timer_on;
    wire        src_edge;
    wire        run_ok;
    wire        fm_on;

    // ==========================================================
    // Synchronised clock edges
    // Each pin clock has its own synchroniser and edge detector;
    // only the one-cycle pulses reach the counters. The
    // detectors reset low, matching the idle pin level, so no
    // false edge follows reset.
    edge_sync u_rc_sync (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .async_in   (internal_rc_clock),
        .rise_pulse (rc_rise)
    );

    edge_sync u_osc_sync (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .async_in   (external_osc_clock),
        .rise_pulse (osc_rise)
    );

    edge_sync u_ref_sync (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .async_in   (reference_clock),
        .rise_pulse (ref_rise)
    );

    // ==========================================================
    // Prescale length; decimal table has no off entry
    // The prescaler counts source edges up to the length less
    // one, then steps the modulus counter. The period ends on
    // the edge that finds both at their limit, so the total is
    // the prescale times the modulus plus one, in edges.
    // Binary lengths are a shift of one base value; decimal
    // ones come from a table of eight entries.
    function [17:0] prescale_of;
        input       dec;
        input [2:0] rate;
        begin
            if (dec) begin
                case (rate)
                    3'h0:    prescale_of = `DEC_PRESCALE_0;
                    3'h1:    prescale_of = `DEC_PRESCALE_1;
                    3'h2:    prescale_of = `DEC_PRESCALE_2;
                    3'h3:    prescale_of = `DEC_PRESCALE_3;
                    3'h4:    prescale_of = `DEC_PRESCALE_4;
                    3'h5:    prescale_of = `DEC_PRESCALE_5;
                    3'h6:    prescale_of = `DEC_PRESCALE_6;
                    default: prescale_of = `DEC_PRESCALE_7;
                endcase
            end else begin
                // Rate 1 gives 2^10, each step doubles up to 2^16
                prescale_of = `BIN_PRESCALE_BASE << rate;
            end
        end
    endfunction

    // ==========================================================
    // Decode
    // Writes except to the interrupt registers are decoded here; reads have their own chain at
    // the bottom, so that a read never disturbs any state.
    assign wr_mod      = reg_wr && (reg_addr == `ADDR_MOD_CTRL);
    assign wr_timer    = reg_wr && (reg_addr == `ADDR_TIMER_CTRL);
    assign wr_cfg      = reg_wr && (reg_addr == `ADDR_CLK_CFG);
    assign decimal_sel = timer_ctrl_q[`TIMER_DEC_BIT];
    assign rate_sel    = timer_ctrl_q[`TIMER_RATE_HI:`TIMER_RATE_LO];
    assign modulus_sel = timer_ctrl_q[`TIMER_MOD_HI:`TIMER_MOD_LO];
    // Binary 000 is off; zero register therefore means stopped
    assign timer_on    = decimal_sel || (rate_sel != `BIN_RATE_OFF);
    assign src_edge    = periodic_clock_select ? osc_rise : rc_rise;
    // Stop mode freezes the count unless pseudo stop runs the oscillator
    assign run_ok      = !stop_mode ||
                         (pseudo_stop_select && pstop_en_q && periodic_clock_select);
    assign fm_on       = modulation_amplitude_hi || modulation_amplitude_lo;

    // ==========================================================
    // Clock select next value and restart conditions
    always @* begin
        clksel_d = periodic_clock_select;
        if (wr_cfg) begin
            // A one only sticks while the oscillator is up
            clksel_d = reg_wdata[`CFG_CLKSEL_BIT] && osc_ready_flag;
        end
        if (!osc_ready_flag) begin
            clksel_d = 1'b0;
        end
        // A change of select, forced or written, is a restart
        restart   = wr_timer || (clksel_d != periodic_clock_select);
        pre_limit = prescale_of(decimal_sel, rate_sel) - 18'd1;
        timeout   = timer_on && run_ok && src_edge && !restart &&
                    (pre_cnt_q == pre_limit) && (mod_cnt_q == modulus_sel);
    end

    // ==========================================================
    // Modulation control register, guarded by lock and clock source
    // A refused write leaves no trace: neither the amplitude
    // nor the clear requests move. The clear requests are
    // pulses only; the status flags live elsewhere.
    always @(posedge sys_clk) begin
        if (!rstn) begin
            modulation_amplitude_hi <= 1'b0;
            modulation_amplitude_lo <= 1'b0;
            clear_lock_status       <= 1'b0;
            clear_osc_ready         <= 1'b0;
        end else begin
            clear_lock_status <= 1'b0;
            clear_osc_ready   <= 1'b0;
            if (wr_mod && !register_lock_flag && loop_clock_select) begin
                // 00 off, 01 1%, 10 2%, 11 4%
                modulation_amplitude_hi <= reg_wdata[`MOD_AMP_HI_BIT];
                modulation_amplitude_lo <= reg_wdata[`MOD_AMP_LO_BIT];
                // Loop must relock, so its status is dropped
                clear_lock_status       <= 1'b1;
                clear_osc_ready         <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Modulation rate: one tick each sixteen reference edges
    // The counter is held at zero while the amplitude is off,
    // so the first tick after an enabling write comes a full
    // sixteen reference edges later. The phase output is the
    // square wave that the loop follows; the deviation itself
    // is set there from the amplitude outputs.
    always @(posedge sys_clk) begin
        if (!rstn) begin
            ref_cnt_q        <= 4'h0;
            modulation_tick  <= 1'b0;
            modulation_phase <= 1'b0;
        end else begin
            modulation_tick <= 1'b0;
            if (!fm_on) begin
                ref_cnt_q        <= 4'h0;
                modulation_phase <= 1'b0;
            end else if (ref_rise) begin
                if (ref_cnt_q == `MOD_REF_DIVIDE) begin
                    ref_cnt_q        <= 4'h0;
                    modulation_tick  <= 1'b1;
                    modulation_phase <= ~modulation_phase;
                end else begin
                    ref_cnt_q <= ref_cnt_q + 4'h1;
                end
            end
        end
    end

    // ==========================================================
    // Timer control, clock configuration and counters
    // Priority in the counter: restart or an off timer first,
    // then the time-out wrap, then an ordinary count.
    // Stop mode only blocks counting and never clears the
    // counters, so a period resumes where it halted once
    // stop mode ends.
    // The clock select follows its next value every cycle,
    // which also carries out the forced clear when the
    // oscillator-ready input drops.
    // The tick trails the time-out cycle by one clock.
    always @(posedge sys_clk) begin
        if (!rstn) begin
            timer_ctrl_q          <= `TIMER_CTRL_RESET;
            periodic_clock_select <= 1'b0;
            pstop_en_q            <= 1'b0;
            pre_cnt_q             <= 18'h00000;
            mod_cnt_q             <= 4'h0;
            periodic_tick         <= 1'b0;
        end else begin
            periodic_tick         <= 1'b0;
            periodic_clock_select <= clksel_d;
            if (wr_timer) begin
                timer_ctrl_q <= reg_wdata;
            end
            if (wr_cfg) begin
                pstop_en_q <= reg_wdata[`CFG_PSTOP_EN_BIT];
            end
            if (restart || !timer_on) begin
                // Fresh period; an off timer holds zero
                pre_cnt_q <= 18'h00000;
                mod_cnt_q <= 4'h0;
            end else if (timeout) begin
                // Wrap and carry on without software help
                pre_cnt_q     <= 18'h00000;
                mod_cnt_q     <= 4'h0;
                periodic_tick <= 1'b1;
            end else if (run_ok && src_edge) begin
                if (pre_cnt_q == pre_limit) begin
                    pre_cnt_q <= 18'h00000;
                    mod_cnt_q <= mod_cnt_q + 4'h1;
                end else begin
                    pre_cnt_q <= pre_cnt_q + 18'd1;
                end
            end
        end
    end

    // ==========================================================
    // Interrupt status (write one to clear, set wins) and mask
    // A set and a clear in one cycle leave the bit set, so a
    // clear on the bus cannot swallow an event that arrived
    // in the same cycle.
    always @(posedge sys_clk) begin
        if (!rstn) begin
            irq_status_q <= 2'h0;
            irq_mask_q   <= `IRQ_MASK_RESET;
        end else begin
            if (reg_wr && (reg_addr == `ADDR_IRQ_MASK)) begin
                irq_mask_q <= reg_wdata[1:0];
            end
            if (reg_wr && (reg_addr == `ADDR_IRQ_STATUS)) begin
                irq_status_q <= (irq_status_q & ~reg_wdata[1:0]) |
                                {modulation_tick, timeout};
            end else begin
                irq_status_q <= irq_status_q | {modulation_tick, timeout};
            end
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);

    // ==========================================================
    // Read data, one cycle after the strobe; unmapped reads zero
    // Read data stand for one cycle and then fall back to zero,
    // so a stale value never looks like a fresh read.
    // Unused bits of every register read as zero.
    always @(posedge sys_clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `ADDR_MOD_CTRL) begin
                reg_rdata <= {2'b00, modulation_amplitude_hi, modulation_amplitude_lo, 4'h0};
            end else if (reg_addr == `ADDR_TIMER_CTRL) begin
                reg_rdata <= timer_ctrl_q;
            end else if (reg_addr == `ADDR_CLK_CFG) begin
                reg_rdata <= {4'h0, pstop_en_q, 1'b0, periodic_clock_select, 1'b0};
            end else if (reg_addr == `ADDR_IRQ_STATUS) begin
                reg_rdata <= {6'h00, irq_status_q};
            end else if (reg_addr == `ADDR_IRQ_MASK) begin
                reg_rdata <= {6'h00, irq_mask_q};
            end else if (reg_addr == `ADDR_TIMER_STATE) begin
                reg_rdata <= {mod_cnt_q, osc_ready_flag, run_ok, timer_on, 1'b0};
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// [periodic_timer_and_fm_control_checker.sv]
`timescale 1ns/1ps
module periodic_timer_checker (
    input wire       sys_clk,
    input wire       rstn,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       register_lock_flag,
    input wire       loop_clock_select,
    input wire       osc_ready_flag,
    input wire       clear_lock_status,
    input wire       clear_osc_ready,
    input wire       modulation_amplitude_hi,
    input wire       modulation_amplitude_lo,
    input wire       modulation_tick,
    input wire       modulation_phase,
    input wire       periodic_clock_select,
    input wire       periodic_tick
);
    // ==========================================================
    // Decoded bus events
    wire       mod_wr  = reg_wr && reg_addr == 8'h3A;
    wire       mod_ok  = !register_lock_flag && loop_clock_select;
    wire       tmr_wr  = reg_wr && reg_addr == 8'h3B;
    wire [1:0] amp     = {modulation_amplitude_hi, modulation_amplitude_lo};
    wire [1:0] w_amp   = reg_wdata[5:4];
    wire       w_sel   = reg_wdata[1];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ==========================================================
    // Properties
    chk_mod_refused: assert property (mod_wr && !mod_ok |=> !clear_lock_status && !clear_osc_ready && $stable(amp))
        else $error("refused modulation write had an effect");
    chk_mod_clears: assert property (mod_wr && mod_ok |=> clear_lock_status && clear_osc_ready)
        else $error("accepted modulation write gave no clear pulses");
    chk_amp_load: assert property (mod_wr && mod_ok |=> amp == $past(w_amp))
        else $error("amplitude outputs differ from written field");
    chk_mod_quiet: assert property (amp == 2'h0 && $past(amp) == 2'h0 |-> !modulation_tick && !modulation_phase)
        else $error("modulation activity while amplitude is off");
    chk_sel_drop: assert property (!osc_ready_flag |=> !periodic_clock_select)
        else $error("clock select not cleared without oscillator");
    chk_sel_write: assert property (reg_wr && reg_addr == 8'h40 && osc_ready_flag |=> periodic_clock_select == $past(w_sel))
        else $error("clock select does not follow write");
    chk_tick_pulse: assert property (periodic_tick |=> !periodic_tick)
        else $error("periodic tick longer than one cycle");
    chk_write_restart: assert property (tmr_wr |-> ##2 !periodic_tick [*3])
        else $error("tick right after timer write");
    chk_ctrl_readback: assert property (tmr_wr ##2 (reg_rd && reg_addr == 8'h3B) |=> reg_rdata == $past(reg_wdata, 3))
        else $error("timer control read back differs");
endmodule

bind periodic_timer_and_fm_control periodic_timer_checker chk_u (
    .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .register_lock_flag,
    .loop_clock_select, .osc_ready_flag, .clear_lock_status, .clear_osc_ready, .modulation_amplitude_hi,
    .modulation_amplitude_lo, .modulation_tick, .modulation_phase, .periodic_clock_select, .periodic_tick
);

// [periodic_timer_defs.vh]
// Operation
// - A write to the modulation control register takes effect only while the lock flag is clear and the loop clock is the system clock.
// - Every accepted write to the modulation control register clears the loop lock and oscillator-ready status bits.
// - With modulation enabled the loop oscillator clock is modulated at the reference clock rate divided by sixteen.
// - The two-bit amplitude field means 00 off, 01 one percent, 10 two percent and 11 four percent deviation.
// - The periodic timer counts the internal RC clock when its clock select is 0 and the external oscillator clock when it is 1.
// - In stop mode the timer keeps counting only in pseudo stop with the oscillator clock selected, and halts otherwise.
// - The timer control register is readable and writable at any time and every write starts a fresh time-out period.
// - Any change of the timer clock select, including the forced clear on oscillator loss, restarts the time-out period.
// - Bit 7 of the timer control register picks binary prescale values when 0 and decimal ones when 1.
// - In binary mode the prescale field at bits 6 to 4 gives off for 000 and two to the 10 up to two to the 16 for 001 to 111.
// - The modulus field at bits 3 to 0 multiplies the prescale by its value plus one, from 1 up to 16.
// - The timer control register resets to zero, which leaves the timer off, and software writes zero to turn it off.
// - The timer clock select can be set only while the oscillator is ready and is cleared when readiness drops.
// - With the pseudo-stop timer enable or the clock select at 0 the timer stays static in stop mode and keeps its count.
`ifndef PERIODIC_TIMER_DEFS_VH
`define PERIODIC_TIMER_DEFS_VH

// ==========================================================
// Register offsets
`define ADDR_MOD_CTRL       8'h3A
`define ADDR_TIMER_CTRL     8'h3B
`define ADDR_CLK_CFG        8'h40
`define ADDR_IRQ_STATUS     8'h41
`define ADDR_IRQ_MASK       8'h42
`define ADDR_TIMER_STATE    8'h43

// ==========================================================
// Field positions
`define MOD_AMP_HI_BIT      5
`define MOD_AMP_LO_BIT      4
`define TIMER_DEC_BIT       7
`define TIMER_RATE_HI       6
`define TIMER_RATE_LO       4
`define TIMER_MOD_HI        3
`define TIMER_MOD_LO        0
`define CFG_CLKSEL_BIT      1
`define CFG_PSTOP_EN_BIT    3
`define IRQ_TIMEOUT_BIT     0
`define IRQ_MODTICK_BIT     1

// ==========================================================
// Reset values
`define MOD_CTRL_RESET      8'h00
`define TIMER_CTRL_RESET    8'h00
`define CLK_CFG_RESET       8'h00
`define IRQ_MASK_RESET      2'h0

// ==========================================================
// Timing counts
`define MOD_REF_DIVIDE      4'hF
`define BIN_RATE_OFF        3'h0
`define BIN_PRESCALE_BASE   18'h00200
`define DEC_PRESCALE_0      18'd1000
`define DEC_PRESCALE_1      18'd2000
`define DEC_PRESCALE_2      18'd5000
`define DEC_PRESCALE_3      18'd10000
`define DEC_PRESCALE_4      18'd20000
`define DEC_PRESCALE_5      18'd50000
`define DEC_PRESCALE_6      18'd100000
`define DEC_PRESCALE_7      18'd200000

`endif

// [tb_periodic_timer_and_fm_control.sv]
`timescale 1ns/1ps
module tb_periodic_timer_and_fm_control;
    reg        sys_clk = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, v;
    reg        register_lock_flag = 1'h0, loop_clock_select = 1'h0, osc_ready_flag = 1'h0;
    reg        stop_mode = 1'h0, pseudo_stop_select = 1'h0, seen_clr;
    reg        internal_rc_clock = 1'h0, external_osc_clock = 1'h0, reference_clock = 1'h0;
    wire [7:0] reg_rdata;
    wire       clear_lock_status, clear_osc_ready, modulation_amplitude_hi, modulation_amplitude_lo;
    wire       modulation_tick, modulation_phase, periodic_clock_select, periodic_tick, irq;
    integer    failures = 0, n_compared = 0, cyc = 0, n, i;

    periodic_timer_and_fm_control dut_u (
        .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .register_lock_flag,
        .loop_clock_select, .osc_ready_flag, .stop_mode, .pseudo_stop_select, .internal_rc_clock,
        .external_osc_clock, .reference_clock, .clear_lock_status, .clear_osc_ready, .modulation_amplitude_hi,
        .modulation_amplitude_lo, .modulation_tick, .modulation_phase, .periodic_clock_select, .periodic_tick, .irq
    );

    // ==========================================================
    // Clocks: pin clocks are slow (period 4 and 6) to stay inside the synchroniser limit
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        internal_rc_clock <= cyc[1];
        reference_clock <= cyc[1];
        if (cyc % 3 == 0) external_osc_clock <= ~external_osc_clock;
        if (cyc == 80000) begin
            failures = failures + 1;
            results;
        end
    end

    // ==========================================================
    // Bus and compare helpers
    task chk(input [8*6-1:0] name, input [31:0] lo, input [31:0] hi, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (((got >= lo) && (got <= hi)) !== 1'h1) begin
                failures = failures + 1;
                $display("BAD %0s exp %0d..%0d got %0d", name, lo, hi, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'h1;
            @(posedge sys_clk);
            reg_wr <= 1'h0;
            #1 seen_clr = clear_lock_status & clear_osc_ready;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(posedge sys_clk);
            reg_addr <= a;
            reg_rd <= 1'h1;
            @(posedge sys_clk);
            reg_rd <= 1'h0;
            #1 chk("rdata", e, e, reg_rdata);
        end
    endtask
    // Bounded wait, so a missing tick ends as a mismatch
    task wait_tick(input integer lo, input integer hi);
        begin
            n = 0;
            while (periodic_tick !== 1'h1 && n < hi + 20) begin
                @(posedge sys_clk);
                #1 n = n + 1;
            end
            chk("period", lo, hi, n);
        end
    endtask
    task per(input [7:0] ctrl, input integer cpe, input integer e);
        begin
            wr(8'h3B, ctrl);
            wait_tick((e - 1) * cpe, (e + 1) * cpe + 8);
        end
    endtask
    task quiet(input integer c);
        begin
            n = 0;
            repeat (c) begin
                @(posedge sys_clk);
                #1 n = n + (periodic_tick === 1'h1);
            end
            chk("ticks", 0, 0, n);
        end
    endtask

    // ==========================================================
    // Scenarios
    task t_reset;
        begin
            rd(8'h3A, 8'h00);
            rd(8'h3B, 8'h00);
            rd(8'h42, 8'h00);
            rd(8'h10, 8'h00);
        end
    endtask
    task t_mod;
        begin
            loop_clock_select <= 1'h1;
            for (i = 0; i < 4; i = i + 1) begin
                v = i * 16;
                wr(8'h3A, v | 8'hCF);
                chk("clear", 1, 1, seen_clr);
                chk("amp", i, i, {modulation_amplitude_hi, modulation_amplitude_lo});
                rd(8'h3A, v);
            end
            register_lock_flag <= 1'h1;
            wr(8'h3A, 8'h10);
            chk("clear", 0, 0, seen_clr);
            register_lock_flag <= 1'h0;
            loop_clock_select <= 1'h0;
            wr(8'h3A, 8'h10);
            chk("clear", 0, 0, seen_clr);
            rd(8'h3A, 8'h30);
        end
    endtask
    // 64 reference edges at divide 16 give four modulation ticks
    task t_modtick;
        begin
            loop_clock_select <= 1'h1;
            // Smallest amplitude keeps the bus clock inside its limit
            wr(8'h3A, 8'h10);
            n = 0;
            repeat (256) begin
                @(posedge sys_clk);
                #1 n = n + (modulation_tick === 1'h1);
            end
            chk("mtick", 3, 5, n);
            chk("irq", 0, 0, irq);
            wr(8'h42, 8'h02);
            chk("irq", 1, 1, irq);
            wr(8'h3A, 8'h00);
            wr(8'h41, 8'h02);
            rd(8'h41, 8'h00);
            chk("irq", 0, 0, irq);
        end
    endtask
    task t_timer;
        begin
            wr(8'h42, 8'h01);
            per(8'h10, 4, 1024);
            chk("irq", 1, 1, irq);
            per(8'h11, 4, 2048);
            per(8'h80, 4, 1000);
            wr(8'h3B, 8'h00);
            wr(8'h41, 8'h01);
            chk("irq", 0, 0, irq);
            wr(8'h3B, 8'h0F);
            quiet(4400);
        end
    endtask
    task t_restart;
        begin
            wr(8'h3B, 8'h10);
            rd(8'h3B, 8'h10);
            repeat (2400) @(posedge sys_clk);
            per(8'h10, 4, 1024);
        end
    endtask
    // Stop holds the count without clearing it
    task t_stop;
        begin
            wr(8'h3B, 8'h10);
            repeat (2048) @(posedge sys_clk);
            stop_mode <= 1'h1;
            quiet(4096);
            stop_mode <= 1'h0;
            wait_tick(2044, 2060);
        end
    endtask
    task t_osc;
        begin
            wr(8'h40, 8'h0A);
            rd(8'h40, 8'h08);
            osc_ready_flag <= 1'h1;
            wr(8'h40, 8'h0A);
            rd(8'h40, 8'h0A);
            pseudo_stop_select <= 1'h1;
            stop_mode <= 1'h1;
            per(8'h10, 6, 1024);
            stop_mode <= 1'h0;
            repeat (3000) @(posedge sys_clk);
            wr(8'h40, 8'h08);
            wait_tick(4092, 4108);
            wr(8'h40, 8'h0A);
            repeat (3000) @(posedge sys_clk);
            osc_ready_flag <= 1'h0;
            wait_tick(4092, 4108);
            chk("sel", 0, 0, periodic_clock_select);
            wr(8'h3B, 8'h00);
        end
    endtask

    task results;
        begin
            if (failures == 0 && n_compared > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'h1;
        t_reset;
        t_mod;
        t_modtick;
        t_timer;
        t_restart;
        t_stop;
        t_osc;
        results;
    end
endmodule
